// ==== rcd_regs.svh ====
// Offsets, field positions, reset values and encodings of the instruction decode core
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH

`define RCD_ADDR_FILE_LAST  6'h1F
`define RCD_ADDR_ACC        6'h20
`define RCD_ADDR_STATUS     6'h21
`define RCD_ADDR_CTRL       6'h22
`define RCD_ADDR_PC         6'h23
`define RCD_ADDR_RET        6'h24

`define RCD_CTRL_RUN        0
`define RCD_CTRL_RESET      8'h00
`define RCD_ST_C            0
`define RCD_ST_NC           1
`define RCD_ST_Z            2
`define RCD_STATUS_MASK     8'h07
`define RCD_PC_RESET        9'h000
`define RCD_PTR_ADDR        5'h04
`define RCD_PTR_RAM_BIT     5
`define RCD_PTR_IRQ_BIT     6
`define RCD_DEST_FILE       1'b1
`define RCD_PHASE_LAST      2'h3

`define RCD_PAT_ADD         12'b0001_11??_????
`define RCD_PAT_AND_LIT     12'b1110_????_????
`define RCD_PAT_AND_FILE    12'b0001_01??_????
`define RCD_PAT_BIT_CLEAR   12'b0100_????_????
`define RCD_PAT_BIT_SET     12'b0101_????_????
`define RCD_PAT_TEST_LOW    12'b0110_????_????
`define RCD_PAT_TEST_HIGH   12'b0111_????_????
`define RCD_PAT_CALL        12'b1001_????_????
`define RCD_PAT_GOTO        12'b101?_????_????
`define RCD_PAT_ZERO_FILE   12'b0000_011?_????
`define RCD_PAT_ZERO_ACC    12'b0000_0100_0000
`define RCD_PAT_DOG_KICK    12'b0000_0000_0100
`define RCD_PAT_DOG_IRQ_CLR 12'b0000_0001_0000
`define RCD_PAT_INVERT      12'b0010_01??_????
`define RCD_PAT_DEC         12'b0000_11??_????
`define RCD_PAT_DEC_SKIP    12'b0010_11??_????
`define RCD_PAT_FREE        12'b0000_0000_0001
`define RCD_PAT_INC         12'b0010_10??_????
`define RCD_PAT_INC_SKIP    12'b0011_11??_????
`define RCD_PAT_OR_LIT      12'b1101_????_????
`define RCD_PAT_OR_FILE     12'b0001_00??_????
`define RCD_PAT_COPY        12'b0010_00??_????

`endif

// ==== rcd_pkg.sv ====
// Types shared by the instruction decode core
package rcd_pkg;

  typedef enum logic [4:0] {
    OTHER_OP, ADD_TO_FILE_OP, AND_LITERAL_OP, AND_FILE_OP, BIT_CLEAR_OP, BIT_SET_OP,
    TEST_SKIP_IF_LOW, TEST_SKIP_IF_HIGH, CALL_OP, GOTO_OP, ZERO_FILE_OP, ZERO_ACCUMULATOR_OP,
    DOG_TIMER_KICK_OP, DOG_IRQ_LATCH_CLEAR_OP, INVERT_FILE_OP, DECREMENT_OP,
    DECREMENT_SKIP_ZERO_OP, FREE_WRITE_OP, INCREMENT_OP, INCREMENT_SKIP_ZERO_OP,
    OR_LITERAL_OP, OR_FILE_OP, COPY_FILE_OP
  } rcd_op_t;

  typedef struct packed {
    rcd_op_t    op;
    logic       dest;
    logic [4:0] fileSel;
    logic [2:0] bitSel;
    logic [8:0] lit;
  } rcd_instr_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcd_bus_req_t;

endpackage : rcd_pkg

// ==== rcd_core_decode.sv ====
// Instruction decode and execute core for the first part of the 12-bit instruction set
//
// How it works
// (RL1) Every instruction is one 12-bit word: opcode field plus operand fields.
// (RL2) Destination bit 0 writes the accumulator, 1 writes the addressed file register.
// (RL3) Bit operations take bit position from bit field, register from file field.
// (RL4) Literal and control operations carry an 8-bit or 9-bit constant per opcode.
// (RL5) One instruction cycle each; two when a skip happens or PC changes.
// (RL6) Each instruction cycle is exactly four oscillator clocks.
// (RL7) Add sums accumulator and register, steers result, updates carry, nibble carry, Z.
// (RL8) Literal AND and OR combine accumulator with constant into accumulator, Z only.
// (RL9) Register AND and OR combine accumulator with register, steer result, update Z.
// (RL10) Bit clear forces chosen bit to 0, bit set to 1; no flags change.
// (RL11) Bit tests skip next instruction when bit clear or set; skip takes two cycles.
// (RL12) Call jumps to 8-bit constant, goto to 9-bit constant; two cycles, no flags.
// (RL13) Register clear and accumulator clear write zero and set Z.
// (RL14) Watchdog kick resets watchdog counter and prescaler; no flags change.
// (RL15) A dedicated operation clears the watchdog interrupt latch; no flags change.
// (RL16) Complement inverts the register, steers the result, updates Z.
// (RL17) Decrement and increment wrap modulo 256, steer the result, update Z.
// (RL18) Decrement or increment with skip store result, skip on zero, flags unchanged.
// (RL19) Free write goes to program RAM or interrupt config per pointer bits 5 and 6.
// (RL20) Copy moves the register to accumulator or back, and updates Z.
// (RL21) A skip discards the fetched next instruction and spends its cycle idle.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "rcd_regs.svh"

module rcd_core_decode (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic [11:0]         progData,
  output logic      [8:0]          progAddr,
  input  wire rcd_pkg::rcd_bus_req_t busReq,
  output logic      [7:0]          busRdata,
  output logic                     dogKick,
  output logic                     dogIrqClear,
  output logic                     progRamWrite,
  output logic                     irqCfgWrite,
  output logic      [7:0]          freeData,
  output logic                     retire
);

  logic [1:0]          phase_q;
  logic [8:0]          pc_q, ret_q;
  logic                dead_q;
  logic [7:0]          acc_q, status_q, ctrl_q;
  logic [7:0]          fileQ [0:31];
  logic [7:0]          rdata_q;
  logic                dogKick_q, dogIrqClear_q, progRamWrite_q, irqCfgWrite_q;
  logic [7:0]          freeData_q;
  logic                retire_q;

  rcd_pkg::rcd_instr_t ins;
  logic                runQ;
  logic                exec, deadStep;
  logic [7:0]          srcVal, ptrVal, aluRes;
  logic                newC, newNc;
  logic                updC, updNc, updZ;
  logic                wrAcc, wrFile;
  logic                skip, jump;
  logic [8:0]          target;
  logic [8:0]          sum9;
  logic [4:0]          sum5;
  logic                busHalted;

  function automatic rcd_pkg::rcd_instr_t decodeWord(input logic [11:0] w);
    rcd_pkg::rcd_instr_t d;
    d.dest    = w[5];
    d.fileSel = w[4:0];
    d.bitSel  = w[7:5];
    d.lit     = w[8:0];
    unique casez (w)
      `RCD_PAT_ADD:         d.op = rcd_pkg::ADD_TO_FILE_OP;
      `RCD_PAT_AND_LIT:     d.op = rcd_pkg::AND_LITERAL_OP;
      `RCD_PAT_AND_FILE:    d.op = rcd_pkg::AND_FILE_OP;
      `RCD_PAT_BIT_CLEAR:   d.op = rcd_pkg::BIT_CLEAR_OP;
      `RCD_PAT_BIT_SET:     d.op = rcd_pkg::BIT_SET_OP;
      `RCD_PAT_TEST_LOW:    d.op = rcd_pkg::TEST_SKIP_IF_LOW;
      `RCD_PAT_TEST_HIGH:   d.op = rcd_pkg::TEST_SKIP_IF_HIGH;
      `RCD_PAT_CALL:        d.op = rcd_pkg::CALL_OP;
      `RCD_PAT_GOTO:        d.op = rcd_pkg::GOTO_OP;
      `RCD_PAT_ZERO_FILE:   d.op = rcd_pkg::ZERO_FILE_OP;
      `RCD_PAT_ZERO_ACC:    d.op = rcd_pkg::ZERO_ACCUMULATOR_OP;
      `RCD_PAT_DOG_KICK:    d.op = rcd_pkg::DOG_TIMER_KICK_OP;
      `RCD_PAT_DOG_IRQ_CLR: d.op = rcd_pkg::DOG_IRQ_LATCH_CLEAR_OP;
      `RCD_PAT_INVERT:      d.op = rcd_pkg::INVERT_FILE_OP;
      `RCD_PAT_DEC:         d.op = rcd_pkg::DECREMENT_OP;
      `RCD_PAT_DEC_SKIP:    d.op = rcd_pkg::DECREMENT_SKIP_ZERO_OP;
      `RCD_PAT_FREE:        d.op = rcd_pkg::FREE_WRITE_OP;
      `RCD_PAT_INC:         d.op = rcd_pkg::INCREMENT_OP;
      `RCD_PAT_INC_SKIP:    d.op = rcd_pkg::INCREMENT_SKIP_ZERO_OP;
      `RCD_PAT_OR_LIT:      d.op = rcd_pkg::OR_LITERAL_OP;
      `RCD_PAT_OR_FILE:     d.op = rcd_pkg::OR_FILE_OP;
      `RCD_PAT_COPY:        d.op = rcd_pkg::COPY_FILE_OP;
      default:              d.op = rcd_pkg::OTHER_OP;
    endcase
    return d;
  endfunction : decodeWord

  assign ins       = decodeWord(progData); // RL1 RL4
  assign runQ      = ctrl_q[`RCD_CTRL_RUN];
  assign exec      = (phase_q == `RCD_PHASE_LAST) && runQ && !dead_q;
  assign deadStep  = (phase_q == `RCD_PHASE_LAST) && runQ && dead_q;
  assign srcVal    = fileQ[ins.fileSel];
  assign ptrVal    = fileQ[`RCD_PTR_ADDR];
  assign busHalted = !runQ;
  assign sum9      = {1'b0, acc_q} + {1'b0, srcVal};
  assign sum5      = {1'b0, acc_q[3:0]} + {1'b0, srcVal[3:0]};

  // Execute stage: result, steering, flag updates and flow change
  always_comb
  begin
    aluRes = srcVal;
    newC   = sum9[8];
    newNc  = sum5[4];
    updC   = 1'b0;
    updNc  = 1'b0;
    updZ   = 1'b0;
    wrAcc  = 1'b0;
    wrFile = 1'b0;
    skip   = 1'b0;
    jump   = 1'b0;
    target = (ins.op == rcd_pkg::GOTO_OP) ? ins.lit : {1'b0, ins.lit[7:0]}; // RL4 RL12
    unique case (ins.op)
      rcd_pkg::ADD_TO_FILE_OP:
      begin
        aluRes = sum9[7:0]; // RL7
        updC   = 1'b1;
        updNc  = 1'b1;
        updZ   = 1'b1;
      end
      rcd_pkg::AND_LITERAL_OP:  aluRes = acc_q & ins.lit[7:0]; // RL8
      rcd_pkg::OR_LITERAL_OP:   aluRes = acc_q | ins.lit[7:0]; // RL8
      rcd_pkg::AND_FILE_OP:     aluRes = acc_q & srcVal; // RL9
      rcd_pkg::OR_FILE_OP:      aluRes = acc_q | srcVal; // RL9
      rcd_pkg::BIT_CLEAR_OP:    aluRes = srcVal & ~(8'h01 << ins.bitSel); // RL3 RL10
      rcd_pkg::BIT_SET_OP:      aluRes = srcVal | (8'h01 << ins.bitSel); // RL3 RL10
      rcd_pkg::TEST_SKIP_IF_LOW:  skip = !srcVal[ins.bitSel]; // RL11
      rcd_pkg::TEST_SKIP_IF_HIGH: skip = srcVal[ins.bitSel]; // RL11
      rcd_pkg::CALL_OP, rcd_pkg::GOTO_OP: jump = 1'b1; // RL12
      rcd_pkg::ZERO_FILE_OP:    aluRes = 8'h00; // RL13
      rcd_pkg::ZERO_ACCUMULATOR_OP: aluRes = 8'h00; // RL13
      rcd_pkg::INVERT_FILE_OP:  aluRes = ~srcVal; // RL16
      rcd_pkg::DECREMENT_OP:    aluRes = srcVal - 8'h01; // RL17
      rcd_pkg::INCREMENT_OP:    aluRes = srcVal + 8'h01; // RL17
      rcd_pkg::DECREMENT_SKIP_ZERO_OP:
      begin
        aluRes = srcVal - 8'h01; // RL18
        skip   = (aluRes == 8'h00);
      end
      rcd_pkg::INCREMENT_SKIP_ZERO_OP:
      begin
        aluRes = srcVal + 8'h01; // RL18
        skip   = (aluRes == 8'h00);
      end
      default: ;
    endcase
    unique case (ins.op)
      rcd_pkg::ADD_TO_FILE_OP, rcd_pkg::AND_FILE_OP, rcd_pkg::OR_FILE_OP, rcd_pkg::INVERT_FILE_OP,
      rcd_pkg::DECREMENT_OP, rcd_pkg::INCREMENT_OP, rcd_pkg::COPY_FILE_OP:
      begin
        wrFile = (ins.dest == `RCD_DEST_FILE); // RL2
        wrAcc  = (ins.dest != `RCD_DEST_FILE);
        updZ   = 1'b1; // RL9 RL16 RL17 RL20
      end
      rcd_pkg::DECREMENT_SKIP_ZERO_OP, rcd_pkg::INCREMENT_SKIP_ZERO_OP:
      begin
        wrFile = (ins.dest == `RCD_DEST_FILE); // RL2 RL18
        wrAcc  = (ins.dest != `RCD_DEST_FILE);
      end
      rcd_pkg::AND_LITERAL_OP, rcd_pkg::OR_LITERAL_OP, rcd_pkg::ZERO_ACCUMULATOR_OP:
      begin
        wrAcc = 1'b1; // RL8 RL13
        updZ  = 1'b1;
      end
      rcd_pkg::ZERO_FILE_OP:
      begin
        wrFile = 1'b1; // RL13
        updZ   = 1'b1;
      end
      rcd_pkg::BIT_CLEAR_OP, rcd_pkg::BIT_SET_OP: wrFile = 1'b1; // RL10
      default: ;
    endcase
  end

  // Four oscillator clocks per instruction cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1; // RL6
  end

  // Program counter, return address and idle second cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_q   <= `RCD_PC_RESET;
      ret_q  <= `RCD_PC_RESET;
      dead_q <= 1'b0;
    end
    else if (exec)
    begin
      dead_q <= jump || skip; // RL5 RL21
      if (jump)
        pc_q <= target; // RL12
      else if (skip)
        pc_q <= pc_q + 9'h002; // RL11 RL18 RL21
      else
        pc_q <= pc_q + 9'h001;
      if (ins.op == rcd_pkg::CALL_OP)
        ret_q <= pc_q + 9'h001;
    end
    else if (deadStep)
      dead_q <= 1'b0; // RL21
  end

  // Accumulator
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      acc_q <= 8'h00;
    else if (exec && wrAcc)
      acc_q <= aluRes; // RL2
    else if (busHalted && busReq.wr && busReq.addr == `RCD_ADDR_ACC)
      acc_q <= busReq.wdata;
  end

  // Status flags
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      status_q <= 8'h00;
    else if (exec)
    begin
      if (updC)
        status_q[`RCD_ST_C] <= newC; // RL7
      if (updNc)
        status_q[`RCD_ST_NC] <= newNc; // RL7
      if (updZ)
        status_q[`RCD_ST_Z] <= (aluRes == 8'h00);
    end
    else if (busHalted && busReq.wr && busReq.addr == `RCD_ADDR_STATUS)
      status_q <= busReq.wdata & `RCD_STATUS_MASK;
  end

  // File registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 32; i++)
        fileQ[i] <= 8'h00;
    end
    else if (exec && wrFile)
      fileQ[ins.fileSel] <= aluRes; // RL2 RL3
    else if (busHalted && busReq.wr && busReq.addr <= `RCD_ADDR_FILE_LAST)
      fileQ[busReq.addr[4:0]] <= busReq.wdata;
  end

  // Control register
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= `RCD_CTRL_RESET;
    else if (busReq.wr && busReq.addr == `RCD_ADDR_CTRL)
      ctrl_q <= busReq.wdata;
  end

  // Side-effect strobes
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dogKick_q      <= 1'b0;
      dogIrqClear_q  <= 1'b0;
      progRamWrite_q <= 1'b0;
      irqCfgWrite_q  <= 1'b0;
      freeData_q     <= 8'h00;
      retire_q       <= 1'b0;
    end
    else
    begin
      dogKick_q      <= exec && ins.op == rcd_pkg::DOG_TIMER_KICK_OP; // RL14
      dogIrqClear_q  <= exec && ins.op == rcd_pkg::DOG_IRQ_LATCH_CLEAR_OP; // RL15
      progRamWrite_q <= exec && ins.op == rcd_pkg::FREE_WRITE_OP && ptrVal[`RCD_PTR_RAM_BIT]; // RL19
      irqCfgWrite_q  <= exec && ins.op == rcd_pkg::FREE_WRITE_OP && ptrVal[`RCD_PTR_IRQ_BIT]; // RL19
      if (exec && ins.op == rcd_pkg::FREE_WRITE_OP)
        freeData_q <= acc_q;
      retire_q       <= (exec && !jump && !skip) || deadStep; // RL5
    end
  end

  // Bus read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 8'h00;
    else if (!busReq.rd)
      rdata_q <= 8'h00;
    else if (busReq.addr <= `RCD_ADDR_FILE_LAST)
      rdata_q <= fileQ[busReq.addr[4:0]];
    else
      case (busReq.addr)
        `RCD_ADDR_ACC:    rdata_q <= acc_q;
        `RCD_ADDR_STATUS: rdata_q <= status_q;
        `RCD_ADDR_CTRL:   rdata_q <= ctrl_q;
        `RCD_ADDR_PC:     rdata_q <= pc_q[7:0];
        `RCD_ADDR_RET:    rdata_q <= ret_q[7:0];
        default:          rdata_q <= 8'h00;
      endcase
  end

  assign progAddr     = pc_q;
  assign busRdata     = rdata_q;
  assign dogKick      = dogKick_q;
  assign dogIrqClear  = dogIrqClear_q;
  assign progRamWrite = progRamWrite_q;
  assign irqCfgWrite  = irqCfgWrite_q;
  assign freeData     = freeData_q;
  assign retire       = retire_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_flow_change;
    exec && (jump || skip);
  endsequence

  sequence s_idle_slot;
    runQ [*4];
  endsequence

  a_cycle_spacing: assert property (exec |=> !exec [*3]) // RL6
    else $error("execute strobes closer than four clocks");
  a_branch_two: assert property (s_flow_change ##1 s_idle_slot |=> retire_q) // RL5
    else $error("branch or skip did not retire in two cycles");
  a_branch_idle: assert property (s_flow_change |=> !retire_q [*4]) // RL21
    else $error("instruction after a skip or jump was not discarded");
  a_add_result: assert property (exec && ins.op == rcd_pkg::ADD_TO_FILE_OP && !ins.dest // RL7
    |=> acc_q == $past(acc_q) + $past(srcVal) && status_q[`RCD_ST_C] == $past(sum9[8]))
    else $error("add result or carry wrong");
  a_dec_wrap: assert property (exec && ins.op == rcd_pkg::DECREMENT_OP && !ins.dest && srcVal == 8'h00 // RL17
    |=> acc_q == 8'hFF && !status_q[`RCD_ST_Z])
    else $error("decrement of zero did not wrap");
  a_zero_acc: assert property (exec && ins.op == rcd_pkg::ZERO_ACCUMULATOR_OP // RL13
    |=> acc_q == 8'h00 && status_q[`RCD_ST_Z])
    else $error("accumulator clear failed");
  a_bit_flags: assert property (exec && (ins.op == rcd_pkg::BIT_SET_OP || ins.op == rcd_pkg::BIT_CLEAR_OP) // RL10
    |=> $stable(status_q))
    else $error("bit operation changed flags");
  a_goto_target: assert property (exec && ins.op == rcd_pkg::GOTO_OP |=> pc_q == $past(ins.lit)) // RL12
    else $error("goto landed on wrong address");
  a_skip_low: assert property (exec && ins.op == rcd_pkg::TEST_SKIP_IF_LOW && !srcVal[ins.bitSel] // RL11
    |=> pc_q == $past(pc_q) + 9'h002)
    else $error("bit test did not skip");
  a_dog_pulse: assert property (exec && ins.op == rcd_pkg::DOG_TIMER_KICK_OP |=> dogKick_q ##1 !dogKick_q) // RL14
    else $error("watchdog kick not a single pulse");
  a_free_route: assert property (exec && ins.op == rcd_pkg::FREE_WRITE_OP // RL19
    |=> progRamWrite_q == $past(ptrVal[`RCD_PTR_RAM_BIT]) && irqCfgWrite_q == $past(ptrVal[`RCD_PTR_IRQ_BIT]))
    else $error("free write routed wrongly");

endmodule : rcd_core_decode

// ==== rcd_prog_mem.sv ====
// Program memory model that feeds instruction words to the decode core
`timescale 1ns/1ns

module rcd_prog_mem (
  input  wire logic        clk_sys,
  input  wire logic [8:0]  progAddr,
  input  wire logic        loadEn,
  input  wire logic [8:0]  loadAddr,
  input  wire logic [11:0] loadData,
  output logic      [11:0] progData
);
  logic [11:0] mem [512];

  // Every word starts as a jump onto itself, so a finished run parks
  initial
  begin
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = {3'b101, 9'(i)};
    end
  end

  always @(posedge clk_sys)
  begin
    if (loadEn)
    begin
      mem[loadAddr] <= loadData;
    end
  end

  // One whole 12-bit word per address
  assign progData = mem[progAddr];
endmodule : rcd_prog_mem

// ==== tb_top.sv ====
// Self-checking testbench for the instruction decode core
`timescale 1ns/1ns

module tb_top;
  logic                  clk_sys;
  logic                  reset_n;
  logic [11:0]           progData;
  logic [8:0]            progAddr;
  rcd_pkg::rcd_bus_req_t busReq;
  logic [7:0]            busRdata;
  logic                  dogKick;
  logic                  dogIrqClear;
  logic                  progRamWrite;
  logic                  irqCfgWrite;
  logic [7:0]            freeData;
  logic                  retire;
  logic                  loadEn;
  logic [8:0]            loadAddr;
  logic [11:0]           loadData;
  int                    n_mismatch = 0;
  int                    checks = 0;
  int                    cyc = 0;
  int                    nPulse [4];
  int                    retQ [$];
  logic [7:0]            expQ [$];
  string                 nameQ [$];
  logic                  rdPend = 1'b0;

  // Base opcode per operation index, operand fields are added later
  localparam logic [11:0] BASE [23] = '{12'h000, 12'h1C0, 12'hE00, 12'h140, 12'h400, 12'h500, 12'h600, 12'h700,
    12'h900, 12'hA00, 12'h060, 12'h040, 12'h004, 12'h010, 12'h240, 12'h0C0, 12'h2C0, 12'h001, 12'h280, 12'h3C0,
    12'hD00, 12'h100, 12'h200};

  rcd_core_decode rcd_core_decode_inst (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .progData     (progData),
    .progAddr     (progAddr),
    .busReq       (busReq),
    .busRdata     (busRdata),
    .dogKick      (dogKick),
    .dogIrqClear  (dogIrqClear),
    .progRamWrite (progRamWrite),
    .irqCfgWrite  (irqCfgWrite),
    .freeData     (freeData),
    .retire       (retire)
  );

  rcd_prog_mem rcd_prog_mem_inst (
    .clk_sys  (clk_sys),
    .progAddr (progAddr),
    .loadEn   (loadEn),
    .loadAddr (loadAddr),
    .loadData (loadData),
    .progData (progData)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Read data, pulses and retire moments as the core produces them
  always @(posedge clk_sys)
  begin
    cyc++;
    if (retire === 1'b1)
      retQ.push_back(cyc);
    nPulse[0] += int'(dogKick === 1'b1);
    nPulse[1] += int'(dogIrqClear === 1'b1);
    nPulse[2] += int'(progRamWrite === 1'b1);
    nPulse[3] += int'(irqCfgWrite === 1'b1);
    if (rdPend)
      check(nameQ.pop_front(), {1'b0, expQ.pop_front()}, {1'b0, busRdata});
    else
      check("busRdata idle", 9'h000, {1'b0, busRdata});
    rdPend = (busReq.rd === 1'b1);
  end

  task automatic bus_op(input logic [5:0] ad, input logic [7:0] dt, input logic ws, input logic rs);
    @(posedge clk_sys);
    busReq <= '{addr: ad, wdata: dt, wr: ws, rd: rs};
  endtask : bus_op

  task automatic bus_rd(input string what, input logic [5:0] ad, input logic [7:0] exp);
    expQ.push_back(exp);
    nameQ.push_back(what);
    bus_op(ad, 8'h00, 1'b0, 1'b1);
  endtask : bus_rd

  task automatic load(input logic [8:0] ad, input logic [11:0] dt);
    @(posedge clk_sys);
    loadEn <= 1'b1;
    loadAddr <= ad;
    loadData <= dt;
  endtask : load

  task automatic do_reset;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    check("progAddr in reset", 9'h000, progAddr);
    @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask : do_reset

  // One operation after a no-op, then the core parks on a self jump
  task automatic run_case(input int i, input int rnd);
    logic [7:0]  a, v, ptr, res, w, f;
    logic [8:0]  sum, kk, pcEnd;
    logic [2:0]  st, s, b;
    logic [4:0]  r;
    logic        d, skip;
    logic [11:0] ins;
    int          gap;
    a = 8'($urandom);
    v = 8'($urandom);
    ptr = 8'($urandom);
    st = 3'($urandom);
    b = 3'($urandom);
    d = 1'($urandom);
    r = 5'(8 + $urandom % 24);
    kk = {1'($urandom), 8'(2 + $urandom % 254)};
    if (rnd == 0)
      v = (i inside {18, 19}) ? 8'hFF : (i == 16) ? 8'h01 : 8'h00;
    ins = BASE[i];
    if (i inside {1, 3, 14, 15, 16, 18, 19, 21, 22})
      ins = ins | {6'h00, d, r};
    if (i inside {4, 5, 6, 7})
      ins = ins | {4'h0, b, r};
    if (i inside {2, 8, 20})
      ins = ins | {4'h0, kk[7:0]};
    if (i == 9)
      ins = ins | {3'h0, kk};
    if (i == 10)
      ins = ins | {7'h00, r};
    sum = {1'b0, a} + {1'b0, v};
    w = a;
    f = v;
    s = st;
    case (i)
      1: res = sum[7:0];
      2: res = a & kk[7:0];
      3: res = a & v;
      10, 11: res = 8'h00;
      14: res = ~v;
      15, 16: res = v - 8'h01;
      18, 19: res = v + 8'h01;
      20: res = a | kk[7:0];
      21: res = a | v;
      default: res = v;
    endcase
    if (i inside {1, 3, 14, 15, 16, 18, 19, 21, 22} && d)
      f = res;
    else if (i inside {1, 2, 3, 11, 14, 15, 16, 18, 19, 20, 21, 22})
      w = res;
    if (i == 10)
      f = res;
    if (i inside {4, 5})
      f[b] = (i == 5);
    if (i inside {1, 2, 3, 10, 11, 14, 15, 18, 20, 21, 22})
      s[2] = (res == 8'h00);
    if (i == 1)
      s[1:0] = {({1'b0, a[3:0]} + {1'b0, v[3:0]}) > 5'h0F, sum[8]};
    skip = (i == 6 && !v[b]) || (i == 7 && v[b]) || (i inside {16, 19} && res == 8'h00);
    pcEnd = skip ? 9'h003 : 9'h002;
    if (i == 8)
      pcEnd = {1'b0, kk[7:0]};
    if (i == 9)
      pcEnd = kk;
    gap = (skip || i inside {8, 9}) ? 8 : 4;
    do_reset;
    retQ.delete();
    nPulse = '{0, 0, 0, 0};
    load(9'h000, 12'h000);
    load(9'h001, ins);
    @(posedge clk_sys);
    loadEn <= 1'b0;
    bus_op(6'h20, a, 1'b1, 1'b0);
    bus_op(6'h21, {5'h00, st}, 1'b1, 1'b0);
    bus_op({1'b0, r}, v, 1'b1, 1'b0);
    bus_op(6'h04, ptr, 1'b1, 1'b0);
    bus_op(6'h22, 8'h01, 1'b1, 1'b0);
    bus_op(6'h00, 8'h00, 1'b0, 1'b0);
    for (int t = 0; t < 60 && retQ.size() < 2; t++)
      @(posedge clk_sys);
    check("retire spacing", 9'(gap), (retQ.size() < 2) ? 9'h000 : 9'(retQ[1] - retQ[0]));
    // Core state other than the control register must ignore bus writes while running
    bus_op({1'b0, r}, ~f, 1'b1, 1'b0);
    bus_op(6'h22, 8'h00, 1'b1, 1'b0);
    bus_op(6'h00, 8'h00, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    bus_rd("accumulator", 6'h20, w);
    bus_rd("file register", {1'b0, r}, f);
    bus_rd("status", 6'h21, {5'h00, s});
    bus_rd("pc low", 6'h23, pcEnd[7:0]);
    if (i == 8)
      bus_rd("return address", 6'h24, 8'h02);
    bus_rd("unmapped", 6'h3F, 8'h00);
    bus_op(6'h00, 8'h00, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check("progAddr", pcEnd, progAddr);
    check("dogKick count", {8'h00, i == 12}, 9'(nPulse[0]));
    check("dogIrqClear count", {8'h00, i == 13}, 9'(nPulse[1]));
    check("progRamWrite count", {8'h00, i == 17 && ptr[5]}, 9'(nPulse[2]));
    check("irqCfgWrite count", {8'h00, i == 17 && ptr[6]}, 9'(nPulse[3]));
    check("freeData", {1'b0, (i == 17) ? a : 8'h00}, {1'b0, freeData});
  endtask : run_case

  initial
  begin
    reset_n = 1'b0;
    busReq = '0;
    loadEn = 1'b0;
    loadAddr = 9'h000;
    loadData = 12'h000;
    nPulse = '{0, 0, 0, 0};
    void'($urandom(32'h3dc7e03f));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    bus_op(6'h23, 8'h55, 1'b1, 1'b0);
    bus_rd("pc after reset", 6'h23, 8'h00);
    bus_rd("control after reset", 6'h22, 8'h00);
    bus_op(6'h00, 8'h00, 1'b0, 1'b0);
    for (int rnd = 0; rnd < 4; rnd++)
      for (int i = 1; i <= 22; i++)
        run_case(i, rnd);
    stop_test;
  end

  // Bound on the whole run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    stop_test;
  end
endmodule : tb_top
